/* rtl/lbd_pkg.sv */
// Purpose: Constants for link and balance-diagnostic configuration bank
// Assumes: APB3 slave, 32-bit data, one aligned word per register
// Notes:   Byte address is four times the register index
// Functional notes
// - Upper loopback routes upper transmit to receive
// - Adaptive bit enables transmitter adaptive mode
// - Lower float bit idles lower drivers undriven
// - Upper float bit idles upper drivers undriven
// - Link bit nine stores and returns written value
// - Polarity mirror shares storage with polarity
// - Polarity sampled only at measurement cycle start
// - Mirrored cell write updates cell enables
// - Mirrored cell read returns current cell enables
package lbd_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int        ADDR_W        = 8;
	localparam int        CELL_N        = 12;
	localparam logic [7:0] LINK_IDX     = 8'h1B;
	localparam logic [7:0] DIAG_IDX     = 8'h1C;
	localparam logic [7:0] MEAS_IDX     = 8'h20;
	localparam logic [7:0] LINK_ADDR    = 8'(LINK_IDX * 4);
	localparam logic [7:0] DIAG_ADDR    = 8'(DIAG_IDX * 4);
	localparam logic [7:0] MEAS_ADDR    = 8'(MEAS_IDX * 4);
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int        LINK_LOOP_BIT  = 15;
	localparam int        LINK_ADP_BIT   = 14;
	localparam int        LINK_LFLT_BIT  = 11;
	localparam int        LINK_UFLT_BIT  = 10;
	localparam int        LINK_RSV_BIT   = 9;
	localparam int        DIAG_ALT_BIT   = 13;
	localparam int        DIAG_POL_BIT   = 12;
	localparam int        CELL_LSB       = 0;
	localparam int        CELL_MSB       = 11;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic        RST_BIT      = 1'h0;
	localparam logic [11:0] RST_CELLS    = 12'h000;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage

/* rtl/lbd_cfg_if.sv */
`timescale 1ns/1ns
// Purpose: Configuration carried from register bank to its helpers
// Assumes: Single clock domain
// Notes:   Bank drives, helpers only read
interface lbd_cfg_if;
	logic        lower_tx_idle_float;
	logic        upper_tx_idle_float;
	logic        polarity;
	logic        mirrored_alt_mux_select;
	logic [11:0] cell_channel_enables;
	modport src (
		output lower_tx_idle_float,
		output upper_tx_idle_float,
		output polarity,
		output mirrored_alt_mux_select,
		output cell_channel_enables
	);
	modport dst (
		input lower_tx_idle_float,
		input upper_tx_idle_float,
		input polarity,
		input mirrored_alt_mux_select,
		input cell_channel_enables
	);
endinterface

/* rtl/lbd_tx_idle.sv */
`timescale 1ns/1ns
// Purpose: One UART transmit driver with selectable idle state
// Assumes: Output enable low while driving
// Notes:   UPPER picks which float bit applies
module lbd_tx_idle
	import lbd_pkg::*;
#(
	parameter bit UPPER = 1'b0
) (
	input  wire logic core_clk,
	input  wire logic srst,
	lbd_cfg_if.dst    cfg,
	input  wire logic tx_active,
	input  wire logic tx_data,
	output logic      pin_out,
	output logic      pin_oe_n
);
	typedef struct packed {
		logic out;
		logic oe_n;
	} lbd_tx_s;
	lbd_tx_s st;
	lbd_tx_s next_st;
	logic    idle_float;

	assign idle_float = UPPER ? cfg.upper_tx_idle_float
				  : cfg.lower_tx_idle_float;

	always_comb begin
		next_st = st;
		if (tx_active) begin
			next_st.out  = tx_data;
			next_st.oe_n = 1'b0;
		end else begin
			// Idle low by default, released when float set
			next_st.out  = 1'b0;
			next_st.oe_n = idle_float;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '{out: 1'b0, oe_n: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign pin_out  = st.out;
	assign pin_oe_n = st.oe_n;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	AST_IDLE_FLOAT: assert property (!tx_active
		&& idle_float |=> pin_oe_n)
		else $error("Idle driver not released");
	AST_IDLE_LOW: assert property (!tx_active
		&& !idle_float |=> !pin_oe_n && !pin_out)
		else $error("Idle driver not low");
endmodule

/* rtl/lbd_meas_latch.sv */
`timescale 1ns/1ns
// Purpose: Settings seen by conversion logic
// Assumes: meas_start is a one-cycle pulse
// Notes:   Polarity frozen through a measurement cycle
module lbd_meas_latch
	import lbd_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic srst,
	lbd_cfg_if.dst    cfg,
	input  wire logic meas_start,
	output logic      conv_polarity,
	output logic      conv_alt_mux,
	output logic [11:0] conv_cells
);
	typedef struct packed {
		logic        pol;
		logic        alt;
		logic [11:0] cells;
	} lbd_ml_s;
	lbd_ml_s st;
	lbd_ml_s next_st;

	always_comb begin
		next_st       = st;
		next_st.alt   = cfg.mirrored_alt_mux_select;
		next_st.cells = cfg.cell_channel_enables;
		// Mid-cycle polarity changes wait for the next start
		if (meas_start) begin
			next_st.pol = cfg.polarity;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '{pol: RST_BIT, alt: RST_BIT, cells: RST_CELLS};
		end else begin
			st <= next_st;
		end
	end

	assign conv_polarity = st.pol;
	assign conv_alt_mux  = st.alt;
	assign conv_cells    = st.cells;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	AST_POL_HOLD: assert property (!meas_start
		|=> $stable(conv_polarity))
		else $error("Polarity changed mid cycle");
	AST_POL_TAKE: assert property (meas_start
		|=> conv_polarity == $past(cfg.polarity))
		else $error("Polarity not taken at start");
endmodule

/* rtl/lbd_regs.sv */
`timescale 1ns/1ns
// Purpose: Link and balance-diagnostic configuration registers on APB
// Assumes: APB3 master, inputs synchronous to core_clk
// Notes:   Cell, polarity and alt-mux bits shared with measurement reg
module lbd_regs
	import lbd_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              upper_tx_active,
	input  wire logic              upper_tx_data,
	input  wire logic              upper_rx_pin,
	output logic                   upper_rx_to_core,
	output logic                   upper_tx_pin_out,
	output logic                   upper_tx_pin_oe_n,
	input  wire logic              lower_tx_active,
	input  wire logic              lower_tx_data,
	output logic                   lower_tx_pin_out,
	output logic                   lower_tx_pin_oe_n,
	output logic                   tx_adaptive_enable,
	input  wire logic              meas_start,
	output logic                   conv_polarity,
	output logic                   conv_alt_mux,
	output logic [11:0]            conv_cells
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        loop;
		logic        adp;
		logic        lflt;
		logic        uflt;
		logic        rsv9;
		logic        pol;
		logic        alt;
		logic [11:0] cells;
		logic        rx_core;
	} lbd_regs_s;

	lbd_regs_s   st;
	lbd_regs_s   next_st;
	logic        setup;
	logic        wr;
	logic        mapped;
	logic [31:0] rd_word;
	logic [18:0] store_bits;

	lbd_cfg_if cfg ();

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign setup  = psel && !penable;
	assign mapped = (paddr == LINK_ADDR) || (paddr == DIAG_ADDR)
		|| (paddr == MEAS_ADDR);
	// Write lands only on the completing edge of a mapped access
	assign wr = psel && penable && st.pready && pwrite && !st.pslverr;
	// Whole user-visible store, gathered for hold checks
	assign store_bits = {st.loop, st.adp, st.lflt, st.uflt, st.rsv9,
		st.pol, st.alt, st.cells};

	always_comb begin
		rd_word = RST_WORD;
		unique case (paddr)
			LINK_ADDR: begin
				rd_word[LINK_LOOP_BIT] = st.loop;
				rd_word[LINK_ADP_BIT]  = st.adp;
				rd_word[LINK_LFLT_BIT] = st.lflt;
				rd_word[LINK_UFLT_BIT] = st.uflt;
				rd_word[LINK_RSV_BIT]  = st.rsv9;
			end
			DIAG_ADDR, MEAS_ADDR: begin
				// Both views read the one shared store
				rd_word[DIAG_ALT_BIT] = st.alt;
				rd_word[DIAG_POL_BIT] = st.pol;
				rd_word[CELL_MSB:CELL_LSB] = st.cells;
			end
			default: begin
				rd_word = RST_WORD;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st         = st;
		// One wait-free access cycle; low again after completion
		next_st.pready  = setup;
		next_st.pslverr = setup && !mapped;
		if (setup) begin
			next_st.prdata = mapped ? rd_word : RST_WORD;
		end
		if (wr) begin
			unique case (paddr)
				LINK_ADDR: begin
					next_st.loop = pwdata[LINK_LOOP_BIT];
					next_st.adp  = pwdata[LINK_ADP_BIT];
					next_st.lflt = pwdata[LINK_LFLT_BIT];
					next_st.uflt = pwdata[LINK_UFLT_BIT];
					next_st.rsv9 = pwdata[LINK_RSV_BIT];
				end
				DIAG_ADDR, MEAS_ADDR: begin
					next_st.alt   = pwdata[DIAG_ALT_BIT];
					next_st.pol   = pwdata[DIAG_POL_BIT];
					next_st.cells = pwdata[CELL_MSB:CELL_LSB];
				end
				default: begin
					next_st.loop = st.loop;
				end
			endcase
		end
		// Loopback bypasses the chain, so a host can find a break
		next_st.rx_core = st.loop ? upper_tx_data : upper_rx_pin;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '{pready: 1'b0, pslverr: 1'b0, prdata: RST_WORD,
				loop: RST_BIT, adp: RST_BIT, lflt: RST_BIT,
				uflt: RST_BIT, rsv9: RST_BIT, pol: RST_BIT,
				alt: RST_BIT, cells: RST_CELLS, rx_core: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs and helpers
	// ----------------------------------------------------------------
	assign prdata             = st.prdata;
	assign pready             = st.pready;
	assign pslverr            = st.pslverr;
	assign upper_rx_to_core   = st.rx_core;
	assign tx_adaptive_enable = st.adp;

	assign cfg.lower_tx_idle_float     = st.lflt;
	assign cfg.upper_tx_idle_float     = st.uflt;
	assign cfg.polarity                = st.pol;
	assign cfg.mirrored_alt_mux_select = st.alt;
	assign cfg.cell_channel_enables    = st.cells;

	lbd_tx_idle #(.UPPER(1'b0)) u_lower_tx (
		.core_clk  (core_clk),
		.srst      (srst),
		.cfg       (cfg.dst),
		.tx_active (lower_tx_active),
		.tx_data   (lower_tx_data),
		.pin_out   (lower_tx_pin_out),
		.pin_oe_n  (lower_tx_pin_oe_n)
	);

	lbd_tx_idle #(.UPPER(1'b1)) u_upper_tx (
		.core_clk  (core_clk),
		.srst      (srst),
		.cfg       (cfg.dst),
		.tx_active (upper_tx_active),
		.tx_data   (upper_tx_data),
		.pin_out   (upper_tx_pin_out),
		.pin_oe_n  (upper_tx_pin_oe_n)
	);

	lbd_meas_latch u_meas (
		.core_clk      (core_clk),
		.srst          (srst),
		.cfg           (cfg.dst),
		.meas_start    (meas_start),
		.conv_polarity (conv_polarity),
		.conv_alt_mux  (conv_alt_mux),
		.conv_cells    (conv_cells)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_wr_link;
		wr && paddr == LINK_ADDR;
	endsequence
	sequence s_wr_cells;
		wr && (paddr == DIAG_ADDR || paddr == MEAS_ADDR);
	endsequence
	sequence s_rd_diag;
		setup && !pwrite && paddr == DIAG_ADDR;
	endsequence
	sequence s_rd_meas;
		setup && !pwrite && paddr == MEAS_ADDR;
	endsequence
	sequence s_rd_link;
		setup && !pwrite && paddr == LINK_ADDR;
	endsequence
	sequence s_gap_rd_link;
		!psel ##1 s_rd_link;
	endsequence
	sequence s_refused;
		psel && penable && pready && pslverr;
	endsequence

	// ----------------------------------------------------------------
	// Link register
	// ----------------------------------------------------------------
	// Receive path looks one cycle behind its source
	AST_LOOP_RX: assert property (st.loop
		|=> upper_rx_to_core == $past(upper_tx_data))
		else $error("Loopback path broken");
	AST_NOLOOP_RX: assert property (!st.loop
		|=> upper_rx_to_core == $past(upper_rx_pin))
		else $error("Receive pin not passed");
	AST_LOOP_TX_DRIVES: assert property (st.loop && upper_tx_active
		|=> !upper_tx_pin_oe_n)
		else $error("Loopback stopped the upper driver");
	AST_LOOP_WR: assert property (s_wr_link
		|=> st.loop == $past(pwdata[LINK_LOOP_BIT]))
		else $error("Loopback bit not written");
	AST_ADP_WR: assert property (s_wr_link
		|=> tx_adaptive_enable == $past(pwdata[LINK_ADP_BIT]))
		else $error("Adaptive bit not written");
	AST_ADP_HOLD: assert property (!(wr && paddr == LINK_ADDR)
		|=> $stable(tx_adaptive_enable))
		else $error("Adaptive bit moved without write");
	AST_LFLT_WR: assert property (s_wr_link
		|=> cfg.lower_tx_idle_float == $past(pwdata[LINK_LFLT_BIT]))
		else $error("Lower float bit not written");
	AST_UFLT_WR: assert property (s_wr_link
		|=> cfg.upper_tx_idle_float == $past(pwdata[LINK_UFLT_BIT]))
		else $error("Upper float bit not written");
	AST_RSV9_RB: assert property (s_wr_link ##1 s_gap_rd_link
		|=> prdata[LINK_RSV_BIT] == $past(pwdata[LINK_RSV_BIT], 3))
		else $error("Bit nine not returned");
	AST_LINK_RD: assert property (s_rd_link
		|=> prdata[LINK_RSV_BIT] == $past(st.rsv9)
		&& prdata[31:16] == 16'h0000 && prdata[13:12] == 2'h0
		&& prdata[8:0] == 9'h000)
		else $error("Link read wrong");

	// ----------------------------------------------------------------
	// Shared measurement store
	// ----------------------------------------------------------------
	// Either view writes the one store, so both read alike
	AST_POL_SHARED: assert property (s_wr_cells
		|=> cfg.polarity == $past(pwdata[DIAG_POL_BIT]))
		else $error("Polarity store not shared");
	AST_ALT_SHARED: assert property (s_wr_cells
		|=> cfg.mirrored_alt_mux_select
		== $past(pwdata[DIAG_ALT_BIT]))
		else $error("Alt mux store not shared");
	AST_CFG_POL_RD: assert property (s_rd_diag
		|=> prdata[DIAG_POL_BIT] == $past(cfg.polarity)
		&& prdata[DIAG_ALT_BIT] == $past(cfg.mirrored_alt_mux_select))
		else $error("Mirror polarity read wrong");
	AST_CELL_WR: assert property (s_wr_cells
		|=> cfg.cell_channel_enables
		== $past(pwdata[CELL_MSB:CELL_LSB]))
		else $error("Cell enables not updated");
	AST_CELL_RD: assert property (s_rd_diag
		|=> prdata[CELL_MSB:CELL_LSB] == $past(st.cells)
		&& prdata[31:14] == 18'h0_0000)
		else $error("Mirror read wrong");
	AST_MEAS_RD: assert property (s_rd_meas
		|=> prdata[CELL_MSB:CELL_LSB]
		== $past(cfg.cell_channel_enables)
		&& prdata[DIAG_POL_BIT] == $past(cfg.polarity))
		else $error("Measurement view read wrong");
	AST_STORE_HOLD: assert property (!wr |=> $stable(store_bits))
		else $error("Store changed without write");

	// ----------------------------------------------------------------
	// Bus protocol
	// ----------------------------------------------------------------
	// Bus answers in one access cycle, never stretched
	AST_APB_READY: assert property (setup |=> pready ##1 !pready)
		else $error("Ready timing wrong");
	AST_READY_CAUSE: assert property (pready |-> $past(setup))
		else $error("Ready without setup");
	AST_RDATA_HOLD: assert property (!setup |=> $stable(prdata))
		else $error("Read data moved between transfers");
	AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
		else $error("Error without ready");
	AST_ERR_UNMAPPED: assert property (setup && !mapped
		|=> pready && pslverr && prdata == RST_WORD)
		else $error("Unmapped access not refused");
	AST_ERR_MAPPED: assert property (setup && mapped |=> !pslverr)
		else $error("Mapped access refused");
	AST_REFUSED_NO_WR: assert property (s_refused |=> $stable(store_bits))
		else $error("Refused write landed");
	// Reset checked with the default disable switched off
	AST_RST_CLEAR: assert property (@(posedge core_clk)
		disable iff (1'b0) srst |=> !pready && !pslverr
		&& prdata == RST_WORD && store_bits == 19'h0_0000)
		else $error("Reset left state behind");
endmodule

/* verif/lbd_link_peer.sv */
`timescale 1ns/1ns
// Purpose: Far end of the upper daisy-chain link
// Assumes: Same clock as the bank
// Notes:   Resolves the shared wire for the bench
module lbd_link_peer
	import lbd_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      rx_pin,
	output logic      wire_lvl
);
	logic last_lvl;
	// No pull on the wire: a float shows the inverse of the last level
	assign wire_lvl = pin_oe_n ? ~last_lvl : pin_out;
	// Toggles each cycle so loopback is told apart from the pin
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_pin   <= 1'b0;
			last_lvl <= 1'b0;
		end else begin
			rx_pin <= ~rx_pin;
			if (!pin_oe_n) last_lvl <= pin_out;
		end
	end
endmodule

/* verif/lbd_bench.sv */
`timescale 1ns/1ns
// Purpose: Self-checking bench for the configuration bank
// Assumes: APB slave answers after one access cycle
// Notes:   Table rows first, hand tests after
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
	n_mismatch++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module link_and_balance_diag_config_bench
	import lbd_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} lbd_row_s;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        upper_tx_active = 1'b0;
	logic        upper_tx_data = 1'b0;
	logic        upper_rx_pin;
	logic        upper_rx_to_core;
	logic        upper_tx_pin_out;
	logic        upper_tx_pin_oe_n;
	logic        lower_tx_active = 1'b0;
	logic        lower_tx_data = 1'b0;
	logic        lower_tx_pin_out;
	logic        lower_tx_pin_oe_n;
	logic        tx_adaptive_enable;
	logic        meas_start = 1'b0;
	logic        conv_polarity;
	logic        conv_alt_mux;
	logic [11:0] conv_cells;
	logic        wire_lvl;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          k;
	lbd_row_s    rows[8] = '{
		'{1'b1, LINK_ADDR, 16'hFFFF, 16'hCE00},
		'{1'b1, LINK_ADDR, 16'h0200, 16'h0200},
		'{1'b1, DIAG_ADDR, 16'hFFFF, 16'h3FFF},
		'{1'b0, MEAS_ADDR, 16'h0000, 16'h3FFF},
		'{1'b1, MEAS_ADDR, 16'h0A5A, 16'h0A5A},
		'{1'b0, DIAG_ADDR, 16'h0000, 16'h0A5A},
		'{1'b1, DIAG_ADDR, 16'h1123, 16'h1123},
		'{1'b0, MEAS_ADDR, 16'h0000, 16'h1123}};
	always #5 core_clk = ~core_clk;
	lbd_regs dut_u (.core_clk, .srst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .upper_tx_active,
		.upper_tx_data, .upper_rx_pin, .upper_rx_to_core,
		.upper_tx_pin_out, .upper_tx_pin_oe_n, .lower_tx_active,
		.lower_tx_data, .lower_tx_pin_out, .lower_tx_pin_oe_n,
		.tx_adaptive_enable, .meas_start, .conv_polarity, .conv_alt_mux,
		.conv_cells);
	lbd_link_peer peer_u (.core_clk, .srst, .pin_out(upper_tx_pin_out),
		.pin_oe_n(upper_tx_pin_oe_n), .rx_pin(upper_rx_pin), .wire_lvl);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test(input bit hung);
		if (hung) n_mismatch++;
		$display("Compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) stop_test(1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse_start;
		meas_start <= 1'b1;
		tick(1);
		meas_start <= 1'b0;
		tick(1);
	endtask
	initial begin
		tick(16);
		srst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, {16'h0, rows[i].d});
			apb(1'b0, rows[i].a, 32'h0);
			`CHK(rd, {16'h0, rows[i].e})
			`CHK(err, 1'b0)
		end
		tick(2);
		`CHK(conv_polarity, 1'b0)
		`CHK({conv_alt_mux, conv_cells}, 13'h0123)
		pulse_start();
		`CHK(conv_polarity, 1'b1)
		apb(1'b1, DIAG_ADDR, 32'h0);
		tick(2);
		`CHK(conv_polarity, 1'b1)
		pulse_start();
		`CHK(conv_polarity, 1'b0)
		apb(1'b1, 8'h04, 32'hFFFF);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h04, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		// Host leaves adaptive mode on only briefly
		apb(1'b1, LINK_ADDR, 32'h4000);
		tick(2);
		`CHK(tx_adaptive_enable, 1'b1)
		apb(1'b1, LINK_ADDR, 32'h0);
		tick(2);
		`CHK(tx_adaptive_enable, 1'b0)
		for (k = 0; k < 4; k++) begin
			apb(1'b1, LINK_ADDR, {20'h0, k[1:0], 10'h000});
			tick(2);
			`CHK(upper_tx_pin_oe_n, k[0])
			`CHK(lower_tx_pin_oe_n, k[1])
			`CHK({upper_tx_pin_out, lower_tx_pin_out}, 2'b00)
		end
		upper_tx_active <= 1'b1;
		upper_tx_data   <= 1'b1;
		lower_tx_active <= 1'b1;
		tick(3);
		`CHK({upper_tx_pin_oe_n, lower_tx_pin_oe_n}, 2'b00)
		`CHK({wire_lvl, lower_tx_pin_out}, 2'b10)
		apb(1'b1, LINK_ADDR, 32'h8000);
		tick(2);
		`CHK(upper_rx_to_core, 1'b1)
		// Even gap keeps the toggling pin level equal at both checks
		upper_tx_data <= 1'b0;
		lower_tx_data <= 1'b1;
		tick(2);
		`CHK(upper_rx_to_core, 1'b0)
		`CHK({wire_lvl, lower_tx_pin_out}, 2'b01)
		apb(1'b1, LINK_ADDR, 32'h0);
		tick(2);
		`CHK(upper_rx_to_core, ~upper_rx_pin)
		// Mid-run reset must clear both views of the shared store
		apb(1'b1, DIAG_ADDR, 32'h3FFF);
		apb(1'b1, LINK_ADDR, 32'hCE00);
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		for (k = 0; k < 3; k++) begin
			apb(1'b0, k == 0 ? LINK_ADDR : k == 1 ? DIAG_ADDR : MEAS_ADDR,
				32'h0);
			`CHK(rd, 32'h0)
		end
		stop_test(1'b0);
	end
endmodule
